// file: bench/tb_twcp_bank.sv
// Self-checking bench for the timer and wake-up control page bank.
// Assumes the bank, its prescaler and the checker are compiled before it.
`timescale 1ns/1ns
module tb_twcp_bank;
    logic       clock, reset, page_sel, io_wr, io_rd, instr_cycle, irq_entry;
    logic       irq_disable_instr, irq_enable_instr, irq_return_instr;
    logic       watchdog_clear_instr, sleep_instr, counter_write;
    logic       ext_irq_pin, count_pin, sub_osc_clock;
    logic [3:0] io_addr, wake_enable;
    logic [7:0] io_wdata, io_rdata, port6_pullup_bit;
    logic       io_hit, sink_strength_select, ext_irq_event, global_irq_on;
    logic       counter_inc, watchdog_on, watchdog_tick;
    logic       down2_clock_pick, down1_clock_pick, low_pulse_clock_pick, high_pulse_clock_pick;
    logic [2:0] down2_prescale_code, down1_prescale_code;
    logic [2:0] low_pulse_prescale_code, high_pulse_prescale_code;
    int         failures = 0, total_checks = 0, inc_n = 0, irq_n = 0, wdt_n = 0, rat;
    logic [7:0] model [6];
    logic       flag_m;
    logic [3:0] flag_tab [5] = '{4'h8, 4'h2, 4'h5, 4'h1, 4'hA};

    twcp_bank dut_u (.clock, .reset, .page_sel, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
        .io_hit, .instr_cycle, .irq_disable_instr, .irq_enable_instr, .irq_return_instr,
        .irq_entry, .watchdog_clear_instr, .sleep_instr, .counter_write, .ext_irq_pin,
        .count_pin, .sub_osc_clock, .sink_strength_select, .wake_enable, .ext_irq_event,
        .global_irq_on, .counter_inc, .watchdog_on, .watchdog_tick, .down2_clock_pick,
        .down2_prescale_code, .down1_clock_pick, .down1_prescale_code, .low_pulse_clock_pick,
        .low_pulse_prescale_code, .high_pulse_clock_pick, .high_pulse_prescale_code,
        .port6_pullup_bit);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        if (counter_inc === 1'b1) inc_n++;
        if (ext_irq_event === 1'b1) irq_n++;
        if (watchdog_tick === 1'b1) wdt_n++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("Checks made %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    // Unused bits are masked out of the model so they read back as zero
    task automatic wr(input logic pg, input logic [3:0] a, input logic [7:0] d);
        page_sel = pg; io_addr = a; io_wdata = d; io_wr = 1'b1;
        cyc(1);
        io_wr = 1'b0;
        if (pg && a >= 4'h6 && a <= 4'hB)
            model[a - 4'h6] = d & (a == 4'h6 ? 8'h8F : a == 4'h7 ? 8'hBF : a == 4'h8 ? 8'h0F : 8'hFF);
    endtask

    task automatic rd(input logic pg, input logic [3:0] a);
        logic hit;
        hit = pg && a >= 4'h6 && a <= 4'hB;
        page_sel = pg; io_addr = a; io_rd = 1'b1;
        cyc(1);
        io_rd = 1'b0;
        check(io_hit, {7'h0, hit}, "read hit");
        if (!hit) check(io_rdata, 8'h00, "refused read");
        else if (a == 4'h7) check(io_rdata, model[1] | {1'b0, flag_m, 6'h0}, "control read");
        else check(io_rdata, model[a - 4'h6], "register read");
    endtask

    task automatic check_outs;
        check({4'h0, wake_enable}, {4'h0, ~model[0][3:0]}, "wake enables");
        check({7'h0, sink_strength_select}, {7'h0, model[0][7]}, "sink select");
        check({7'h0, watchdog_on}, {7'h0, model[2][3]}, "watchdog on");
        check({down2_clock_pick, down2_prescale_code, down1_clock_pick, down1_prescale_code},
              model[3], "down counter fields");
        check({low_pulse_clock_pick, low_pulse_prescale_code, high_pulse_clock_pick,
               high_pulse_prescale_code}, model[4], "pulse timer fields");
        check(port6_pullup_bit, model[5], "pull-high enables");
    endtask

    task automatic sub_edge;
        sub_osc_clock = 1'b1;
        cyc(5);
        sub_osc_clock = 1'b0;
        cyc(5);
    endtask

    initial begin
        #40000;
        failures++;
        $display("CHECK FAILED at %0t: run did not finish in time", $time);
        final_report;
    end

    initial begin
        {page_sel, io_wr, io_rd, instr_cycle, irq_disable_instr, irq_enable_instr} = '0;
        {irq_return_instr, irq_entry, watchdog_clear_instr, sleep_instr, counter_write} = '0;
        {ext_irq_pin, count_pin, sub_osc_clock} = '0;
        io_addr = 4'h0; io_wdata = 8'h00; reset = 1'b1; flag_m = 1'b0;
        model = '{8'h00, 8'hBF, 8'h00, 8'h00, 8'h00, 8'h00};
        void'($urandom(34));
        cyc(4);
        reset = 1'b0;
        for (int a = 4; a < 14; a++) rd(1'b1, a[3:0]);
        check_outs;
        $display("Test reset values done");
        for (int i = 0; i < 60; i++) begin
            wr($urandom_range(0, 3) != 0, 4'($urandom_range(4, 13)), 8'($urandom));
            rd($urandom_range(0, 4) != 0, 4'($urandom_range(5, 12)));
            check_outs;
        end
        $display("Test random access done");
        foreach (flag_tab[i]) begin
            {irq_enable_instr, irq_return_instr, irq_disable_instr, irq_entry} = flag_tab[i];
            cyc(1);
            {irq_enable_instr, irq_return_instr, irq_disable_instr, irq_entry} = 4'h0;
            flag_m = flag_tab[i][3] | flag_tab[i][2];
            rd(1'b1, 4'h7);
            check({7'h0, global_irq_on}, {7'h0, flag_m}, "global flag");
        end
        $display("Test global flag done");
        // One stray event before the clear: a prescaler left uncleared gives two ticks at every ratio from 1:2 to 1:256
        for (int n = 0; n < 9; n++) begin
            rat = n < 8 ? 2 << n : 1;
            wr(1'b1, 4'h7, n < 8 ? {5'b00001, n[2:0]} : 8'h00);
            pulse(instr_cycle);
            cyc(1);
            pulse(counter_write);
            cyc(2);
            inc_n = 0;
            repeat (2 * rat - 1) begin pulse(instr_cycle); cyc(1); end
            cyc(2);
            check(8'(inc_n), 8'h01, "counter ticks");
        end
        $display("Test counter prescaler done");
        for (int e = 0; e < 2; e++) begin
            wr(1'b1, 4'h7, e ? 8'hB0 : 8'h20);
            cyc(6);
            inc_n = 0; irq_n = 0;
            {ext_irq_pin, count_pin} = 2'b11;
            pulse(instr_cycle);
            cyc(8);
            check(8'(inc_n), e ? 8'h00 : 8'h01, "pin count after rise");
            check(8'(irq_n), e ? 8'h00 : 8'h01, "interrupt after rise");
            {ext_irq_pin, count_pin} = 2'b00;
            cyc(9);
            check(8'(inc_n), 8'h01, "pin count after fall");
            check(8'(irq_n), 8'h01, "interrupt after fall");
        end
        $display("Test pin edges done");
        for (int n = 0; n < 4; n++) begin
            rat = n < 3 ? 1 << n : 1;
            wr(1'b1, 4'h8, n < 3 ? {5'b00001, n[2:0]} : 8'h00);
            sub_edge;
            if (n[0]) pulse(sleep_instr);
            else pulse(watchdog_clear_instr);
            cyc(2);
            wdt_n = 0;
            repeat (2 * rat - 1) sub_edge;
            check(8'(wdt_n), n < 3 ? 8'h01 : 8'h00, "watchdog ticks");
        end
        $display("Test watchdog done");
        final_report;
    end
endmodule // tb_twcp_bank

// file: bench/twcp_bank_sva.sv
// Concurrent checks on the ports of the timer and wake-up control page bank.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module twcp_bank_sva (
    // System
    input wire logic       clock,
    input wire logic       reset,
    // Register access
    input wire logic       page_sel,
    input wire logic [3:0] io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       io_hit,
    // Events and outputs
    input wire logic       irq_disable_instr,
    input wire logic       irq_enable_instr,
    input wire logic       irq_return_instr,
    input wire logic       irq_entry,
    input wire logic       global_irq_on,
    input wire logic [3:0] wake_enable,
    input wire logic       watchdog_on,
    input wire logic       watchdog_tick,
    input wire logic       counter_inc,
    input wire logic       ext_irq_event,
    input wire logic [7:0] port6_pullup_bit
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire       mapped  = page_sel && io_addr >= 4'h6 && io_addr <= 4'hB;
    wire       set_req = irq_enable_instr || irq_return_instr;
    wire       clr_req = irq_disable_instr || irq_entry;
    wire [3:0] wd_low  = io_wdata[3:0];

    a_read_hit: assert property (io_rd && mapped |=> io_hit)
        else $error("mapped read gave no hit");
    a_read_miss:
        assert property (io_rd && !mapped |=> !io_hit && io_rdata == 8'h00)
        else $error("unmapped read answered");
    a_write_refused: assert property (io_wr && !mapped |=> $stable(port6_pullup_bit))
        else $error("refused write changed a register");
    a_wake_write:
        assert property (io_wr && mapped && io_addr == 4'h6 |=> wake_enable == ~$past(wd_low))
        else $error("wake enables do not follow the written bits");
    a_pullup_write:
        assert property (io_wr && mapped && io_addr == 4'hB |=> port6_pullup_bit == $past(io_wdata))
        else $error("pull-high enables do not follow the written byte");
    a_flag_set: assert property (set_req |=> global_irq_on)
        else $error("global flag not set");
    a_flag_clear: assert property (clr_req && !set_req |=> !global_irq_on)
        else $error("global flag not cleared");
    a_flag_read:
        assert property (io_rd && mapped && io_addr == 4'h7 |=> io_rdata[6] == $past(global_irq_on))
        else $error("read-only flag bit wrong");
    a_wdt_gated: assert property (!watchdog_on [*2] |-> !watchdog_tick)
        else $error("watchdog tick while disabled");
    a_reset_vals:
        assert property ($past(reset) |-> wake_enable == 4'hF && !io_hit && !global_irq_on)
        else $error("wrong state after reset");

    cover property (io_rd && mapped ##1 io_hit);
    cover property (watchdog_tick);
    cover property (counter_inc);
    cover property (ext_irq_event);
endmodule // twcp_bank_sva

bind twcp_bank twcp_bank_sva chk_u (.clock, .reset, .page_sel, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .io_hit, .irq_disable_instr, .irq_enable_instr, .irq_return_instr,
    .irq_entry, .global_irq_on, .wake_enable, .watchdog_on, .watchdog_tick, .counter_inc,
    .ext_irq_event, .port6_pullup_bit);

// file: hw/twcp_bank.sv
// Timer and wake-up control page: six 8-bit control registers on page 1.
// Assumes the CPU drives single-cycle read/write strobes on the instruction clock,
// and that page_sel mirrors bit 0 of the port-5 page register.
`timescale 1ns/1ns

// How it works
// - Registers answer at addresses 06h to 0Bh only while page select is 1.
// - Wake-up bits 3..0 are active-low enables for P8 high/low, P6 high/low nibbles.
// - Wake-up enable bits reset to 0, so every group starts enabled.
// - Counter control bit 7 picks external interrupt edge: 0 rising, 1 falling.
// - Counter control bit 6 is read-only, showing the global interrupt enable flag.
// - Counter control bit 5 picks counter source: instruction clock or counter pin.
// - Counter control bit 4 picks counting pin edge: 0 rising, 1 falling.
// - Bit 3 low gives rate 1:1; high gives 1:2^(n+1) from bits 2..0.
// - Watchdog control bit 3 enables the watchdog.
// - Watchdog bits 2..0 set prescale ratio 1:2^n, 1:1 up to 1:128.
// - Watchdog prescaler counts sub-oscillator edges, never the main oscillator.
// - Down-counter bit 7 picks counter 2 clock: 0 sub, 1 main oscillator.
// - Down-counter bits 6..4 set counter 2 prescale 1:2^(n+1).
// - Down-counter bit 3 picks counter 1 clock: 0 sub, 1 main oscillator.
// - Down-counter bits 2..0 set counter 1 prescale 1:2^(n+1).
// - Pulse-width bit 7 picks low-pulse timer clock: 0 sub, 1 main.
// - Pulse-width bits 6..4 set low-pulse timer prescale 1:2^(n+1).
// - Pulse-width bit 3 picks high-pulse timer clock: 0 sub, 1 main.
// - Pulse-width bits 2..0 set high-pulse timer prescale 1:2^(n+1).
// - Each port 6 pull-high bit enables that pin's pull-high when 1.
// - Reset sets all counter control bits to 1 except the interrupt flag.
// - Watchdog clear or sleep clears watchdog prescaler; counter write clears counter prescaler.
module twcp_bank (
    // System
    input  wire logic       clock,
    input  wire logic       reset,
    // Control register access
    input  wire logic       page_sel,
    input  wire logic [3:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    output logic            io_hit,
    // Instruction events
    input  wire logic       instr_cycle,
    input  wire logic       irq_disable_instr,
    input  wire logic       irq_enable_instr,
    input  wire logic       irq_return_instr,
    input  wire logic       irq_entry,
    input  wire logic       watchdog_clear_instr,
    input  wire logic       sleep_instr,
    input  wire logic       counter_write,
    // Pins
    input  wire logic       ext_irq_pin,
    input  wire logic       count_pin,
    input  wire logic       sub_osc_clock,
    // Wake-up and sink current
    output logic            sink_strength_select,
    output logic      [3:0] wake_enable,
    // Interrupt edge and global flag
    output logic            ext_irq_event,
    output logic            global_irq_on,
    // Time clock counter and watchdog
    output logic            counter_inc,
    output logic            watchdog_on,
    output logic            watchdog_tick,
    // Down counters and pulse-width timers
    output logic            down2_clock_pick,
    output logic      [2:0] down2_prescale_code,
    output logic            down1_clock_pick,
    output logic      [2:0] down1_prescale_code,
    output logic            low_pulse_clock_pick,
    output logic      [2:0] low_pulse_prescale_code,
    output logic            high_pulse_clock_pick,
    output logic      [2:0] high_pulse_prescale_code,
    // Port 6 pull-high
    output logic      [7:0] port6_pullup_bit
);

    // Register storage
    logic [7:0] wake_q;
    logic [7:0] cnt_q;
    logic [7:0] wdt_q;
    logic [7:0] down_q;
    logic [7:0] pulse_q;
    logic [7:0] pullup_q;
    logic       gie_q;
    logic       gie_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       hit_q;
    logic       wake_out_q;
    logic [3:0] wake_en_q;

    // Pin filters
    logic [twcp_pkg::SYNC_DEPTH-1:0] sync_q [twcp_pkg::PIN_COUNT];
    logic [twcp_pkg::PIN_COUNT-1:0]  lvl_q;
    logic [twcp_pkg::PIN_COUNT-1:0]  lvl_d;
    logic [twcp_pkg::PIN_COUNT-1:0]  rise;
    logic [twcp_pkg::PIN_COUNT-1:0]  fall;
    logic                            irq_evt_q;

    twcp_pre_if pre_link ();

    // Address decode
    wire on_page  = page_sel;
    wire sel_wake = on_page & (io_addr == twcp_pkg::ADDR_WAKEUP);
    wire sel_cnt  = on_page & (io_addr == twcp_pkg::ADDR_COUNTER);
    wire sel_wdt  = on_page & (io_addr == twcp_pkg::ADDR_WATCHDOG);
    wire sel_down = on_page & (io_addr == twcp_pkg::ADDR_DOWN);
    wire sel_pw   = on_page & (io_addr == twcp_pkg::ADDR_PULSE);
    wire sel_ph   = on_page & (io_addr == twcp_pkg::ADDR_PULLUP);
    wire any_sel  = sel_wake | sel_cnt | sel_wdt | sel_down | sel_pw | sel_ph;

    // Write data per register; read-only and unused bits are written as zero
    wire [7:0] wake_wd = io_wdata & twcp_pkg::WAKE_WMASK;
    wire [7:0] cnt_wd  = io_wdata & twcp_pkg::CNT_WMASK;
    wire [7:0] wdt_wd  = io_wdata & twcp_pkg::WDT_WMASK;

    // Counter control view with the live interrupt flag in bit 6
    wire [7:0] cnt_view = {cnt_q[7], gie_q, cnt_q[5:0]};

    // Read selection
    assign rdata_d = sel_wake ? wake_q   :
                     sel_cnt  ? cnt_view :
                     sel_wdt  ? wdt_q    :
                     sel_down ? down_q   :
                     sel_pw   ? pulse_q  :
                     sel_ph   ? pullup_q : 8'h00;

    // Global interrupt flag: an enable in the same cycle as a mask wins
    wire gie_set = irq_enable_instr | irq_return_instr;
    wire gie_clr = irq_disable_instr | irq_entry;
    assign gie_d = gie_set ? 1'b1 : (gie_clr ? 1'b0 : gie_q);

    always_ff @(posedge clock) begin
        if (reset) begin
            wake_q   <= twcp_pkg::WAKE_RESET;
            cnt_q    <= twcp_pkg::CNT_RESET;
            wdt_q    <= twcp_pkg::WDT_RESET;
            down_q   <= twcp_pkg::DOWN_RESET;
            pulse_q  <= twcp_pkg::PULSE_RESET;
            pullup_q <= twcp_pkg::PULLUP_RESET;
            gie_q    <= 1'b0;
        end else begin
            if (io_wr && sel_wake) wake_q   <= wake_wd;
            if (io_wr && sel_cnt)  cnt_q    <= cnt_wd;
            if (io_wr && sel_wdt)  wdt_q    <= wdt_wd;
            if (io_wr && sel_down) down_q   <= io_wdata;
            if (io_wr && sel_pw)   pulse_q  <= io_wdata;
            if (io_wr && sel_ph)   pullup_q <= io_wdata;
            gie_q <= gie_d;
        end
    end

    // Read port: data and hit are registered one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= 8'h00;
            hit_q   <= 1'b0;
        end else begin
            rdata_q <= io_rd ? rdata_d : rdata_q;
            hit_q   <= io_rd & any_sel;
        end
    end

    // Pin filters: a new level counts once the second and third stages agree
    wire [twcp_pkg::PIN_COUNT-1:0] pin_raw = {sub_osc_clock, count_pin, ext_irq_pin};

    always_ff @(posedge clock) begin
        for (int i = 0; i < twcp_pkg::PIN_COUNT; i++) begin
            sync_q[i] <= {sync_q[i][twcp_pkg::SYNC_DEPTH-2:0], pin_raw[i]};
        end
    end

    always_comb begin
        for (int i = 0; i < twcp_pkg::PIN_COUNT; i++) begin
            lvl_d[i] = (sync_q[i][1] == sync_q[i][2]) ? sync_q[i][2] : lvl_q[i];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= lvl_d;
        end
    end

    assign rise = lvl_d & ~lvl_q;
    assign fall = ~lvl_d & lvl_q;

    // External interrupt edge
    wire irq_edge = cnt_q[twcp_pkg::CNT_EDGE_BIT] ? fall[twcp_pkg::PIN_IRQ]
                                                  : rise[twcp_pkg::PIN_IRQ];

    // Counter source; pin edges are only seen reliably when slower than the
    // instruction clock, which the filter latency does not correct for
    wire pin_edge = cnt_q[twcp_pkg::CNT_PEDGE_BIT] ? fall[twcp_pkg::PIN_COUNT_IN]
                                                   : rise[twcp_pkg::PIN_COUNT_IN];
    wire tcc_src  = cnt_q[twcp_pkg::CNT_SRC_BIT] ? pin_edge : instr_cycle;

    // Prescaler link
    assign pre_link.tcc_evt    = tcc_src;
    assign pre_link.tcc_bypass = ~cnt_q[twcp_pkg::CNT_PRE_BIT];
    assign pre_link.tcc_code   = cnt_q[2:0];
    assign pre_link.tcc_clear  = counter_write;
    // Watchdog counts filtered sub-oscillator rising edges only
    assign pre_link.wdt_evt    = rise[twcp_pkg::PIN_SUB_OSC];
    assign pre_link.wdt_on     = wdt_q[twcp_pkg::WDT_ON_BIT];
    assign pre_link.wdt_code   = wdt_q[2:0];
    assign pre_link.wdt_clear  = watchdog_clear_instr | sleep_instr;

    twcp_prescale u_prescale (
        .clock (clock),
        .reset (reset),
        .pre   (pre_link.pre)
    );

    // Next values of the wake-up register fields, so outputs track a write at once
    wire [7:0] wake_next   = (io_wr && sel_wake) ? wake_wd : wake_q;
    wire       wake_d_sink = wake_next[twcp_pkg::WAKE_SINK_BIT];
    wire [3:0] wake_d_bits = wake_next[3:0];

    // Registered outputs that are not already register bits
    always_ff @(posedge clock) begin
        if (reset) begin
            irq_evt_q  <= 1'b0;
            wake_out_q <= 1'b0;
            wake_en_q  <= 4'hF;
        end else begin
            irq_evt_q  <= irq_edge;
            wake_out_q <= wake_d_sink;
            wake_en_q  <= ~wake_d_bits;
        end
    end

    // Outputs
    assign io_rdata                 = rdata_q;
    assign io_hit                   = hit_q;
    assign sink_strength_select     = wake_out_q;
    assign wake_enable              = wake_en_q;
    assign ext_irq_event            = irq_evt_q;
    assign global_irq_on            = gie_q;
    assign counter_inc              = pre_link.tcc_tick;
    assign watchdog_on              = wdt_q[twcp_pkg::WDT_ON_BIT];
    assign watchdog_tick            = pre_link.wdt_tick;
    assign down2_clock_pick         = down_q[twcp_pkg::HI_SEL_BIT];
    assign down2_prescale_code      = down_q[6:4];
    assign down1_clock_pick         = down_q[twcp_pkg::LO_SEL_BIT];
    assign down1_prescale_code      = down_q[2:0];
    assign low_pulse_clock_pick     = pulse_q[twcp_pkg::HI_SEL_BIT];
    assign low_pulse_prescale_code  = pulse_q[6:4];
    assign high_pulse_clock_pick    = pulse_q[twcp_pkg::LO_SEL_BIT];
    assign high_pulse_prescale_code = pulse_q[2:0];
    assign port6_pullup_bit         = pullup_q;

endmodule // twcp_bank

// file: hw/twcp_pkg.sv
// Constants for the timer and wake-up control page of the paged control space.
// Assumes an 8-bit control bus with a 4-bit control address and a page-select bit.
package twcp_pkg;

    // Control addresses on page 1
    localparam logic [3:0] ADDR_WAKEUP   = 4'h6;
    localparam logic [3:0] ADDR_COUNTER  = 4'h7;
    localparam logic [3:0] ADDR_WATCHDOG = 4'h8;
    localparam logic [3:0] ADDR_DOWN     = 4'h9;
    localparam logic [3:0] ADDR_PULSE    = 4'hA;
    localparam logic [3:0] ADDR_PULLUP   = 4'hB;

    // Wake-up and sink current register
    localparam int WAKE_SINK_BIT = 7;
    localparam logic [7:0] WAKE_WMASK = 8'h8F;
    localparam logic [7:0] WAKE_RESET = 8'h00;

    // Counter clock control register
    localparam int CNT_EDGE_BIT  = 7;
    localparam int CNT_GIE_BIT   = 6;
    localparam int CNT_SRC_BIT   = 5;
    localparam int CNT_PEDGE_BIT = 4;
    localparam int CNT_PRE_BIT   = 3;
    localparam logic [7:0] CNT_WMASK = 8'hBF;
    localparam logic [7:0] CNT_RESET = 8'hBF;

    // Watchdog control register
    localparam int WDT_ON_BIT = 3;
    localparam logic [7:0] WDT_WMASK = 8'h0F;
    localparam logic [7:0] WDT_RESET = 8'h00;

    // Plain read/write registers
    localparam logic [7:0] DOWN_RESET   = 8'h00;
    localparam logic [7:0] PULSE_RESET  = 8'h00;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam int HI_SEL_BIT = 7;
    localparam int LO_SEL_BIT = 3;

    // Pin input filter depth
    localparam int SYNC_DEPTH = 3;
    localparam int PIN_COUNT  = 3;
    localparam int PIN_IRQ    = 0;
    localparam int PIN_COUNT_IN = 1;
    localparam int PIN_SUB_OSC  = 2;

    // Prescale selection: mask of low counter bits that must all be set for a tick.
    // A ratio of 1:2^k needs the low k bits set; plus_one adds one to k.
    function automatic logic [7:0] twcp_pre_mask(input logic [2:0] code,
                                                 input logic       plus_one);
        logic [3:0] k;
        logic [8:0] full;
        k    = {1'b0, code} + {3'h0, plus_one};
        full = (9'h001 << k) - 9'h001;
        return full[7:0];
    endfunction

endpackage

// file: hw/twcp_pre_if.sv
// Link between the register bank and its prescaler block.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface twcp_pre_if;
    logic       tcc_evt;
    logic       tcc_bypass;
    logic [2:0] tcc_code;
    logic       tcc_clear;
    logic       tcc_tick;
    logic       wdt_evt;
    logic       wdt_on;
    logic [2:0] wdt_code;
    logic       wdt_clear;
    logic       wdt_tick;

    modport bank (output tcc_evt, tcc_bypass, tcc_code, tcc_clear,
                  output wdt_evt, wdt_on, wdt_code, wdt_clear,
                  input  tcc_tick, wdt_tick);
    modport pre  (input  tcc_evt, tcc_bypass, tcc_code, tcc_clear,
                  input  wdt_evt, wdt_on, wdt_code, wdt_clear,
                  output tcc_tick, wdt_tick);
endinterface

// file: hw/twcp_prescale.sv
// Prescalers for the time clock counter and the watchdog.
// Assumes source events are single-cycle pulses on the system clock.
`timescale 1ns/1ns
module twcp_prescale (
    // System
    input wire logic clock,
    input wire logic reset,
    // Bank side
    twcp_pre_if.pre  pre
);

    logic [7:0] tcc_cnt_q;
    logic [7:0] tcc_cnt_d;
    logic [7:0] wdt_cnt_q;
    logic [7:0] wdt_cnt_d;
    logic       tcc_tick_q;
    logic       wdt_tick_q;
    wire  [7:0] tcc_mask = twcp_pkg::twcp_pre_mask(pre.tcc_code, 1'b1);
    wire  [7:0] wdt_mask = twcp_pkg::twcp_pre_mask(pre.wdt_code, 1'b0);
    wire        tcc_hit  = ((tcc_cnt_q & tcc_mask) == tcc_mask);
    wire        wdt_hit  = ((wdt_cnt_q & wdt_mask) == wdt_mask);

    // Clear beats a coincident event, matching an instruction that rewrites the count
    assign tcc_cnt_d = pre.tcc_clear ? 8'h00 :
                       pre.tcc_evt   ? tcc_cnt_q + 8'h01 : tcc_cnt_q;
    assign wdt_cnt_d = pre.wdt_clear ? 8'h00 :
                       pre.wdt_evt   ? wdt_cnt_q + 8'h01 : wdt_cnt_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            tcc_cnt_q  <= 8'h00;
            wdt_cnt_q  <= 8'h00;
            tcc_tick_q <= 1'b0;
            wdt_tick_q <= 1'b0;
        end else begin
            tcc_cnt_q  <= tcc_cnt_d;
            wdt_cnt_q  <= wdt_cnt_d;
            tcc_tick_q <= pre.tcc_evt & ~pre.tcc_clear & (pre.tcc_bypass | tcc_hit);
            wdt_tick_q <= pre.wdt_evt & ~pre.wdt_clear & pre.wdt_on & wdt_hit;
        end
    end

    assign pre.tcc_tick = tcc_tick_q;
    assign pre.wdt_tick = wdt_tick_q;

endmodule // twcp_prescale
